// ==== dv/srg_assertions.sv ====
`timescale 1ns/1ps
module srg_assertions
  import srg_pkg::*;
#(
  parameter int DW = 16
) (
  input wire logic clock, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic cw_valid, // Control write strobe
  input wire logic cw_sel, // Control register select
  input wire logic [7:0] cw_data, // Control value
  input wire logic xfer_req_b, // Transfer request, active low
  input wire logic [DW-1:0] pkt_data, // Packet word
  input wire logic [7:0] pkt_status, // Packet status
  input wire logic pkt_ack, // Packet taken
  input wire logic frame_locked, // Frame sync
  input wire logic blk_locked // Block sync
);
  logic srst;
  logic gated;
  logic vec_all;
  logic next_gated;
  logic next_vec_all;
  assign srst = cw_valid && cw_sel == CW_SEL_CTRL1
    && cw_data[CTRL1_SYNC_RST_BIT];
  // With vec_all clear, vertical output stays shut from a sync reset until frame lock
  always_comb begin
    next_gated = gated;
    next_vec_all = vec_all;
    if (srst) next_gated = 1'h1;
    else if (frame_locked) next_gated = 1'h0;
    if (cw_valid && cw_sel == CW_SEL_CTRL2) begin
      next_vec_all = cw_data[CTRL2_VEC_ALL_BIT];
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gated <= 1'h1;
      vec_all <= 1'h0;
    end else begin
      gated <= next_gated;
      vec_all <= next_vec_all;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_sync_unlock;
    srst |=> !blk_locked && !frame_locked;
  endproperty
  a_sync_unlock: assert property (p_sync_unlock)
    else $error("sync reset left a lock set");
  property p_sync_drop;
    srst |=> xfer_req_b;
  endproperty
  a_sync_drop: assert property (p_sync_drop)
    else $error("sync reset kept a waiting packet");
  property p_no_early_lock;
    srst |=> !frame_locked [*8];
  endproperty
  a_no_early_lock: assert property (p_no_early_lock)
    else $error("frame lock came back too soon");
  property p_vgate;
    gated && !vec_all && !xfer_req_b |-> !pkt_status[STAT_VH_BIT];
  endproperty
  a_vgate: assert property (p_vgate)
    else $error("vertical packet before frame lock");
  property p_stand;
    !xfer_req_b && !pkt_ack && !srst |=>
      !xfer_req_b && $stable(pkt_data) && $stable(pkt_status);
  endproperty
  a_stand: assert property (p_stand)
    else $error("waiting packet changed");
  property p_ack_release;
    pkt_ack |=> xfer_req_b;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("request held after ack");
  property p_ack_on_req;
    pkt_ack |-> !xfer_req_b;
  endproperty
  a_ack_on_req: assert property (p_ack_on_req)
    else $error("ack without request");
  property p_retune_pair;
    cw_valid && cw_sel == CW_SEL_CTRL1 |=>
      cw_valid && cw_sel == CW_SEL_CTRL2;
  endproperty
  a_retune_pair: assert property (p_retune_pair)
    else $error("retune not followed by control 2 write");
endmodule : srg_assertions

// ==== dv/tb_sync_reset_output_gating.sv ====
`timescale 1ns/1ps
module tb_sync_reset_output_gating;
  import srg_pkg::*;
  logic clock, rst_b, blk_tick, blk_bic_ok, blk_alt, frame_mark;
  logic vpass_done, h_valid, h_ready, v_valid, v_ok, v_ready;
  logic sync_rst_pulse, psel, penable, pwrite, pready, pslverr;
  logic err, took;
  logic [15:0] h_data, v_data;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int bad_count, n_checks;
  srg_link_if #(.DW(16)) link_bus (.clock(clock), .rst_b(rst_b));
  srg_device #(.DW(16)) u_srg_device (.clock(clock), .rst_b(rst_b),
    .link(link_bus), .blk_tick(blk_tick), .blk_bic_ok(blk_bic_ok),
    .blk_alt(blk_alt), .frame_mark(frame_mark), .vpass_done(vpass_done),
    .h_valid(h_valid), .h_data(h_data), .h_ready(h_ready),
    .v_valid(v_valid), .v_ok(v_ok), .v_data(v_data), .v_ready(v_ready),
    .sync_rst_pulse(sync_rst_pulse));
  srg_host #(.DW(16)) u_srg_host (.clock(clock), .rst_b(rst_b),
    .link(link_bus), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  srg_assertions #(.DW(16)) u_srg_assertions (.clock(clock),
    .rst_b(rst_b), .cw_valid(link_bus.cw_valid),
    .cw_sel(link_bus.cw_sel), .cw_data(link_bus.cw_data),
    .xfer_req_b(link_bus.xfer_req_b), .pkt_data(link_bus.pkt_data),
    .pkt_status(link_bus.pkt_status), .pkt_ack(link_bus.pkt_ack),
    .frame_locked(link_bus.frame_locked),
    .blk_locked(link_bus.blk_locked));
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic hang(input string what);
    bad_count++;
    $display("Error %s expected answer seen timeout", what);
    print_verdict();
  endtask : hang
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      if (pready === 1'h1) break;
    end
    if (i == 16) hang("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // Register read with masked compare
  task automatic rdchk(input string what, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(what, exp, rd & m);
  endtask : rdchk
  // Control writes wait for the command sequencer to go idle
  task automatic ctrl(input logic [31:0] d);
    int i;
    for (i = 0; i < 16; i++) begin
      apb(1'h0, HOST_STAT_OFS, 32'h0);
      if (rd[3] === 1'h0) break;
    end
    if (i == 16) hang("busy");
    apb(1'h1, HOST_CTRL_OFS, d);
  endtask : ctrl
  task automatic tick(input logic alt, input logic mark);
    @(posedge clock);
    blk_tick <= 1'h1;
    blk_bic_ok <= 1'h1;
    blk_alt <= alt;
    frame_mark <= mark;
    @(posedge clock);
    blk_tick <= 1'h0;
  endtask : tick
  task automatic frames(input int n, input int off);
    for (int f = 0; f < n; f++) begin
      for (int k = 0; k < FRAME_BLOCKS; k++) tick(1'h0, k == off);
    end
  endtask : frames
  task automatic offer(input logic vert, input logic [15:0] d,
      input int lim);
    @(posedge clock);
    h_valid <= !vert;
    h_data <= d;
    v_valid <= vert;
    v_data <= d;
    took = 1'h0;
    for (int i = 0; i < lim && !took; i++) begin
      @(negedge clock);
      took = vert ? v_ready : h_ready;
      @(posedge clock);
    end
    h_valid <= 1'h0;
    v_valid <= 1'h0;
  endtask : offer
  initial begin
    rst_b = 1'h0;
    {blk_tick, blk_bic_ok, blk_alt, frame_mark, vpass_done} = 5'h00;
    {h_valid, v_valid, psel, penable, pwrite} = 5'h00;
    v_ok = 1'h1;
    h_data = 16'h0000;
    v_data = 16'h0000;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clock);
    rst_b <= 1'h1;
    rdchk("ctrl", HOST_CTRL_OFS, 32'hF, HOST_CTRL_RESET);
    rdchk("status", HOST_STAT_OFS, 32'hF, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    tick(1'h0, 1'h0);
    rdchk("blk_lock", HOST_STAT_OFS, 32'h6, 32'h4);
    frames(4, 0);
    rdchk("fr_lock", HOST_STAT_OFS, 32'h6, 32'h6);
    offer(1'h0, 16'h1234, 20);
    offer(1'h0, 16'h5678, 20);
    ctrl(32'h1);
    @(negedge clock);
    @(negedge clock);
    chk("flush_pulse", 32'h1, {31'h0, sync_rst_pulse});
    @(negedge clock);
    chk("flush_end", 32'h0, {31'h0, sync_rst_pulse});
    rdchk("unlock", HOST_STAT_OFS, 32'h6, 32'h0);
    rdchk("h_data", HOST_DATA_OFS, 32'h80FFFF, 32'h1234);
    rdchk("flushed", HOST_STAT_OFS, 32'h1, 32'h0);
    offer(1'h0, 16'h0001, 20);
    rdchk("h_gated", HOST_DATA_OFS, 32'h80FFFF, 32'h0001);
    offer(1'h1, 16'hA5A5, 8);
    chk("v_unlocked", 32'h0, {31'h0, took});
    frames(4, 0);
    offer(1'h1, 16'hA5A5, 8);
    chk("v_no_pass", 32'h0, {31'h0, took});
    @(posedge clock);
    vpass_done <= 1'h1;
    @(posedge clock);
    vpass_done <= 1'h0;
    offer(1'h1, 16'hC3C3, 20);
    chk("v_open", 32'h1, {31'h0, took});
    rdchk("v_data", HOST_DATA_OFS, 32'hC0FFFF, 32'hC0C3C3);
    ctrl(32'h3);
    offer(1'h1, 16'h0F0F, 20);
    chk("v_all", 32'h1, {31'h0, took});
    rdchk("drop", HOST_DROP_OFS, 32'hFF, 32'h1);
    rdchk("no_avail", HOST_STAT_OFS, 32'h1, 32'h0);
    frames(4, 0);
    rdchk("relock", HOST_STAT_OFS, 32'h2, 32'h2);
    frames(6, 100);
    rdchk("fwd_hold", HOST_STAT_OFS, 32'h2, 32'h2);
    frames(1, 100);
    rdchk("fwd_lost", HOST_STAT_OFS, 32'h2, 32'h0);
    frames(3, 100);
    rdchk("new_lock", HOST_STAT_OFS, 32'h2, 32'h2);
    ctrl(32'h4);
    repeat (10) tick(1'h1, 1'h0);
    offer(1'h0, 16'hBEEF, 20);
    rdchk("sub_lock", HOST_STAT_OFS, 32'h2, 32'h2);
    rdchk("sub_pkt", HOST_DATA_OFS, 32'hA0FFFF, 32'h20BEEF);
    frames(2, 100);
    rdchk("back_main", HOST_STAT_OFS, 32'h2, 32'h2);
    offer(1'h0, 16'h0BAD, 20);
    rdchk("held", HOST_STAT_OFS, 32'h1, 32'h1);
    ctrl(32'h8);
    rdchk("purged", HOST_STAT_OFS, 32'h1, 32'h0);
    rdchk("purge_rd", HOST_CTRL_OFS, 32'hF, 32'h0);
    // Two block code misses in a row drop block lock only
    repeat (2) begin
      @(posedge clock);
      blk_tick <= 1'h1;
      blk_bic_ok <= 1'h0;
      @(posedge clock);
      blk_tick <= 1'h0;
    end
    rdchk("blk_lost", HOST_STAT_OFS, 32'h6, 32'h2);
    print_verdict();
  end
endmodule : tb_sync_reset_output_gating

// ==== hw/srg_device.sv ====
`timescale 1ns/1ps
module srg_device
  import srg_pkg::*;
#(
  parameter int DW = 16,
  parameter int PW = 4,
  parameter logic [PW-1:0] BLK_BACK = PW'(BLK_BACK_DEF),
  parameter logic [PW-1:0] BLK_FWD = PW'(BLK_FWD_DEF),
  parameter logic [PW-1:0] FR_BACK = PW'(FR_BACK_DEF),
  parameter logic [PW-1:0] FR_FWD = PW'(FR_FWD_DEF)
) (
  input wire logic clock, // 20 MHz clock
  input wire logic rst_b, // Async reset, active low
  srg_link_if.device link, // Host side link
  input wire logic blk_tick, // One pulse per block period
  input wire logic blk_bic_ok, // Block code matched on this tick
  input wire logic blk_alt, // Tick came from a shifted timing
  input wire logic frame_mark, // Frame sync word in this block
  input wire logic vpass_done, // Vertical pass finished
  input wire logic h_valid, // Horizontal packet offered
  input wire logic [DW-1:0] h_data, // Horizontal packet word
  output logic h_ready, // Horizontal packet taken
  input wire logic v_valid, // Vertical packet offered
  input wire logic v_ok, // Vertical correction succeeded
  input wire logic [DW-1:0] v_data, // Vertical packet word
  output logic v_ready, // Vertical packet taken
  output logic sync_rst_pulse // Flush pulse to the datapath
);
  localparam logic [8:0] FRAME_LAST = 9'(FRAME_BLOCKS - 1);

  function automatic logic [8:0] frame_step(input logic [8:0] pos);
    frame_step = (pos == FRAME_LAST) ? 9'h000 : pos + 9'h001;
  endfunction : frame_step

  srg_frame_t fstate;
  srg_frame_t next_fstate;
  logic blk_lock;
  logic next_blk_lock;
  logic [8:0] frame_pos;
  logic [8:0] next_frame_pos;
  logic vec_gate;
  logic next_vec_gate;
  logic vec_all_en;
  logic next_vec_all_en;
  logic sub_mode;
  logic next_sub_mode;
  logic sync_rst;
  logic next_sync_rst;
  logic out_valid;
  logic next_out_valid;
  logic [DW-1:0] out_data;
  logic [DW-1:0] next_out_data;
  logic [7:0] out_status;
  logic [7:0] next_out_status;
  logic blk_acq_done;
  logic blk_loss_done;
  logic fr_acq_done;
  logic fr_loss_done;
  logic cw_sync_rst;
  logic frame_lock;
  logic at_frame_head;
  logic fr_check;
  logic v_pass_allowed;

  assign cw_sync_rst = link.cw_valid && link.cw_sel == CW_SEL_CTRL1 &&
                       link.cw_data[CTRL1_SYNC_RST_BIT];
  assign frame_lock = (fstate != FR_HUNT);
  assign at_frame_head = (frame_pos == 9'h000);
  // Frame checks are skipped while block timing sits on a sub-station
  assign fr_check = blk_tick && at_frame_head && fstate == FR_LOCK;

  // Block synchronisation protection
  srg_prot_cnt #(.CW(PW)) u_blk_acq (
    .clock(clock),
    .rst_b(rst_b),
    .clear(cw_sync_rst || blk_lock),
    .hit(blk_tick && blk_bic_ok),
    .miss(blk_tick && !blk_bic_ok),
    .limit(BLK_BACK),
    .reached(blk_acq_done)
  );
  srg_prot_cnt #(.CW(PW)) u_blk_loss (
    .clock(clock),
    .rst_b(rst_b),
    .clear(cw_sync_rst || !blk_lock),
    .hit(blk_tick && !blk_bic_ok),
    .miss(blk_tick && blk_bic_ok),
    .limit(BLK_FWD),
    .reached(blk_loss_done)
  );
  // Frame synchronisation protection
  srg_prot_cnt #(.CW(PW)) u_fr_acq (
    .clock(clock),
    .rst_b(rst_b),
    .clear(cw_sync_rst || fstate != FR_HUNT),
    .hit(blk_tick && at_frame_head && frame_mark),
    .miss(blk_tick && at_frame_head && !frame_mark),
    .limit(FR_BACK),
    .reached(fr_acq_done)
  );
  srg_prot_cnt #(.CW(PW)) u_fr_loss (
    .clock(clock),
    .rst_b(rst_b),
    .clear(cw_sync_rst || fstate != FR_LOCK),
    .hit(fr_check && !frame_mark),
    .miss(fr_check && frame_mark),
    .limit(FR_FWD),
    .reached(fr_loss_done)
  );

  // Control writes and synchronisation state
  always_comb begin
    next_vec_all_en = vec_all_en;
    next_sub_mode = sub_mode;
    next_sync_rst = cw_sync_rst;
    next_blk_lock = blk_lock;
    next_fstate = fstate;
    next_frame_pos = frame_pos;
    next_vec_gate = vec_gate;
    if (link.cw_valid && link.cw_sel == CW_SEL_CTRL2) begin
      next_vec_all_en = link.cw_data[CTRL2_VEC_ALL_BIT];
      next_sub_mode = link.cw_data[CTRL2_SUB_MODE_BIT];
    end
    // Lock only changes through protection counts or reset
    if (blk_acq_done) begin
      next_blk_lock = 1'b1;
    end else if (blk_loss_done) begin
      next_blk_lock = 1'b0;
    end
    if (blk_tick) begin
      next_frame_pos = frame_step(frame_pos);
    end
    case (fstate)
      FR_HUNT: begin
        // A mark off the current phase restarts the count at it
        if (blk_tick && frame_mark && !at_frame_head) begin
          next_frame_pos = 9'h001;
        end
        if (fr_acq_done) begin
          next_fstate = FR_LOCK;
        end
      end
      FR_LOCK: begin
        if (fr_loss_done) begin
          next_fstate = FR_HUNT;
          next_vec_gate = 1'b0;
        end else if (blk_tick && blk_alt && sub_mode) begin
          next_fstate = FR_HOLD;
        end
      end
      FR_HOLD: begin
        // Frame lock rides through the false block timing
        if (blk_tick && !blk_alt) begin
          next_fstate = FR_LOCK;
        end
      end
      default: begin
        next_fstate = FR_HUNT;
      end
    endcase
    if (frame_lock && vpass_done) begin
      next_vec_gate = 1'b1;
    end
    if (cw_sync_rst) begin
      next_blk_lock = 1'b0;
      next_fstate = FR_HUNT;
      next_frame_pos = 9'h000;
      next_vec_gate = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      vec_all_en <= CTRL2_RESET[CTRL2_VEC_ALL_BIT];
      sub_mode <= CTRL2_RESET[CTRL2_SUB_MODE_BIT];
      sync_rst <= 1'b0;
      blk_lock <= 1'b0;
      fstate <= FR_HUNT;
      frame_pos <= 9'h000;
      vec_gate <= 1'b0;
    end else begin
      vec_all_en <= next_vec_all_en;
      sub_mode <= next_sub_mode;
      sync_rst <= next_sync_rst;
      blk_lock <= next_blk_lock;
      fstate <= next_fstate;
      frame_pos <= next_frame_pos;
      vec_gate <= next_vec_gate;
    end
  end

  // Output selection: horizontal first, vertical only behind the gate or while vec_all_en is set
  assign v_pass_allowed = vec_gate || vec_all_en;
  assign h_ready = !out_valid && !cw_sync_rst;
  assign v_ready = !out_valid && !cw_sync_rst && !h_valid &&
                   v_pass_allowed;

  always_comb begin
    next_out_valid = out_valid;
    next_out_data = out_data;
    next_out_status = out_status;
    if (cw_sync_rst) begin
      next_out_valid = 1'b0; // The waiting old station packet is withdrawn from the link
    end else if (out_valid) begin
      if (link.pkt_ack) begin
        next_out_valid = 1'b0;
      end
    end else if (h_valid) begin
      // Sub-station packets leave here in real time
      next_out_valid = 1'b1;
      next_out_data = h_data;
      next_out_status = 8'h00;
      next_out_status[STAT_VH_BIT] = 1'b0;
      next_out_status[STAT_SUB_BIT] = (fstate == FR_HOLD);
    end else if (v_valid && v_pass_allowed) begin
      // Main station data recovered by vertical correction
      next_out_valid = 1'b1;
      next_out_data = v_data;
      next_out_status = 8'h00;
      next_out_status[STAT_VH_BIT] = 1'b1;
      next_out_status[STAT_VOK_BIT] = v_ok;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data <= '0;
      out_status <= 8'h00;
    end else begin
      out_valid <= next_out_valid;
      out_data <= next_out_data;
      out_status <= next_out_status;
    end
  end

  assign link.xfer_req_b = !out_valid;
  assign link.pkt_data = out_data;
  assign link.pkt_status = out_status;
  assign link.frame_locked = frame_lock;
  assign link.blk_locked = blk_lock;
  assign sync_rst_pulse = sync_rst;
endmodule : srg_device

// ==== hw/srg_host.sv ====
`timescale 1ns/1ps
module srg_host
  import srg_pkg::*;
#(
  parameter int DW = 16
) (
  input wire logic clock, // 20 MHz clock
  input wire logic rst_b, // Async reset, active low
  srg_link_if.host link, // Device side link
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr // APB error on unmapped address
);
  srg_cmd_t cstate;
  srg_cmd_t next_cstate;
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic avail;
  logic next_avail;
  logic [DW-1:0] pkt;
  logic [DW-1:0] next_pkt;
  logic [7:0] pst;
  logic [7:0] next_pst;
  logic [15:0] drops;
  logic [15:0] next_drops;
  logic [31:0] next_prdata;
  logic mapped;
  logic wr_acc;
  logic rd_acc;
  logic take;
  logic reject;

  assign mapped = paddr == HOST_CTRL_OFS || paddr == HOST_STAT_OFS ||
                  paddr == HOST_DATA_OFS || paddr == HOST_DROP_OFS;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_acc = psel && penable && !pwrite && mapped;
  // Packets are fetched only while the device requests
  assign take = !link.xfer_req_b && !avail;
  // With HC_VEC_ALL_BIT set, vertical packets ahead of relock are acknowledged and dropped
  assign reject = ctrl[HC_VEC_ALL_BIT] && !link.frame_locked &&
                  link.pkt_status[STAT_VH_BIT];
  assign link.pkt_ack = take;

  // Command sequencer toward the device control registers
  always_comb begin
    next_cstate = cstate;
    next_ctrl = ctrl;
    link.cw_valid = 1'b0;
    link.cw_sel = CW_SEL_CTRL2;
    link.cw_data = 8'h00;
    link.cw_data[CTRL2_VEC_ALL_BIT] = ctrl[HC_VEC_ALL_BIT];
    link.cw_data[CTRL2_SUB_MODE_BIT] = ctrl[HC_SUB_MODE_BIT];
    case (cstate)
      HC_IDLE: begin
        if (wr_acc && paddr == HOST_CTRL_OFS) begin
          next_ctrl = pwdata;
          next_ctrl[HC_PURGE_BIT] = 1'b0;
          next_cstate = pwdata[HC_RETUNE_BIT] ? HC_SEND1 : HC_SEND2;
        end
      end
      HC_SEND1: begin
        // Retune: unlock the device together with the tuner
        link.cw_valid = 1'b1;
        link.cw_sel = CW_SEL_CTRL1;
        link.cw_data = 8'h00;
        link.cw_data[CTRL1_SYNC_RST_BIT] = 1'b1;
        next_ctrl[HC_RETUNE_BIT] = 1'b0;
        next_cstate = HC_SEND2;
      end
      HC_SEND2: begin
        link.cw_valid = 1'b1;
        next_cstate = HC_IDLE;
      end
      default: begin
        next_cstate = HC_IDLE;
      end
    endcase
  end

  // Packet holding register and APB read path
  always_comb begin
    next_avail = avail;
    next_pkt = pkt;
    next_pst = pst;
    next_drops = drops;
    next_prdata = prdata;
    if (rd_acc && paddr == HOST_DATA_OFS) begin
      next_avail = 1'b0;
    end
    if (wr_acc && paddr == HOST_CTRL_OFS && pwdata[HC_PURGE_BIT]) begin
      next_avail = 1'b0; // Software purge of a stray packet
    end
    if (take && reject) begin
      next_drops = drops + 16'h0001;
    end else if (take) begin
      // Every packet not rejected is kept, parity look-alikes included
      next_avail = 1'b1;
      next_pkt = link.pkt_data;
      next_pst = link.pkt_status;
    end
    if (psel && !penable) begin
      case (paddr)
        HOST_CTRL_OFS: next_prdata = ctrl;
        HOST_STAT_OFS: next_prdata = {28'h0000000, cstate != HC_IDLE,
                                      link.blk_locked, link.frame_locked,
                                      avail};
        HOST_DATA_OFS: next_prdata = {8'h00, pst, 16'(pkt)};
        HOST_DROP_OFS: next_prdata = {16'h0000, drops};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cstate <= HC_IDLE;
      ctrl <= HOST_CTRL_RESET;
      avail <= 1'b0;
      pkt <= '0;
      pst <= 8'h00;
      drops <= 16'h0000;
      prdata <= 32'h0000_0000;
    end else begin
      cstate <= next_cstate;
      ctrl <= next_ctrl;
      avail <= next_avail;
      pkt <= next_pkt;
      pst <= next_pst;
      drops <= next_drops;
      prdata <= next_prdata;
    end
  end
endmodule : srg_host

// ==== hw/srg_prot_cnt.sv ====
`timescale 1ns/1ps
module srg_prot_cnt
  import srg_pkg::*;
#(
  parameter int CW = 4
) (
  input wire logic clock, // Clock
  input wire logic rst_b, // Async reset, active low
  input wire logic clear, // Restart the count
  input wire logic hit, // Event to count
  input wire logic miss, // Breaks a run of events
  input wire logic [CW-1:0] limit, // Run length needed
  output logic reached // Run of limit events seen
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (clear || miss) begin
      next_cnt = '0;
    end else if (hit && cnt != limit) begin
      next_cnt = cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign reached = hit && !clear && (cnt + 1'b1 >= limit);
endmodule : srg_prot_cnt

// ==== include/srg_link_if.sv ====
`timescale 1ns/1ps
interface srg_link_if #(
  parameter int DW = 16
) (
  input wire logic clock, // Shared clock
  input wire logic rst_b // Async reset, active low
);
  logic cw_valid; // Host control write strobe
  logic cw_sel; // 0 control 1, 1 control 2
  logic [7:0] cw_data; // Control write value
  logic xfer_req_b; // Transfer request, low active
  logic [DW-1:0] pkt_data; // Packet word
  logic [7:0] pkt_status; // Packet status byte
  logic pkt_ack; // Host took the packet
  logic frame_locked; // Frame sync state
  logic blk_locked; // Block sync state

  modport device (
    input cw_valid, cw_sel, cw_data, pkt_ack,
    output xfer_req_b, pkt_data, pkt_status, frame_locked, blk_locked
  );
  modport host (
    output cw_valid, cw_sel, cw_data, pkt_ack,
    input xfer_req_b, pkt_data, pkt_status, frame_locked, blk_locked
  );
endinterface : srg_link_if

// ==== include/srg_pkg.sv ====
package srg_pkg;
  // Link control write selects
  localparam logic CW_SEL_CTRL1 = 1'h0;
  localparam logic CW_SEL_CTRL2 = 1'h1;
  // Control register 1 and 2 field positions
  localparam int CTRL1_SYNC_RST_BIT = 4;
  localparam int CTRL2_VEC_ALL_BIT = 2;
  localparam int CTRL2_SUB_MODE_BIT = 7;
  // Packet status field positions
  localparam int STAT_VH_BIT = 7;
  localparam int STAT_VOK_BIT = 6;
  localparam int STAT_SUB_BIT = 5;
  // Frame structure and protection defaults
  localparam int FRAME_BLOCKS = 272;
  localparam int BLK_BACK_DEF = 1;
  localparam int BLK_FWD_DEF = 2;
  localparam int FR_BACK_DEF = 2;
  localparam int FR_FWD_DEF = 7;
  // Host APB register offsets
  localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam logic [7:0] HOST_DATA_OFS = 8'h08;
  localparam logic [7:0] HOST_DROP_OFS = 8'h0C;
  // Host control bits
  localparam int HC_RETUNE_BIT = 0;
  localparam int HC_VEC_ALL_BIT = 1;
  localparam int HC_SUB_MODE_BIT = 2;
  localparam int HC_PURGE_BIT = 3;
  // Reset values
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [31:0] HOST_CTRL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    FR_HUNT = 2'b00,
    FR_LOCK = 2'b01,
    FR_HOLD = 2'b10
  } srg_frame_t;

  typedef enum logic [1:0] {
    HC_IDLE = 2'b00,
    HC_SEND1 = 2'b01,
    HC_SEND2 = 2'b10
  } srg_cmd_t;
endpackage : srg_pkg
